/* dv/rth_htiming_monitor.sv */
// checker: bus answer and character timing assertions for the horizontal timing block
`timescale 1ns/1ns
module rth_htiming_monitor
    import rth_pkg::*;
#(
    parameter int COUNT_W = 9 // counter width, handed on from the design
) (
    input wire logic               core_clk_i,
    input wire logic               arst_n_i,
    input wire logic [15:0]        io_addr_i,
    input wire logic               io_rd_i,
    input wire logic [7:0]         io_rdata_o,
    input wire logic               io_rvalid_o,
    input wire logic               color_sel_i,
    input wire logic               dot8_sel_i,
    input wire logic               char_tick_o,
    input wire logic [COUNT_W-1:0] hcount_o,
    input wire logic               hblank_o,
    input wire logic               hsync_o,
    input wire logic               disp_en_o
);
    logic [15:0] ip_sel; // index port of the current colour choice
    logic        idx_rd; // read of the index port
    logic        hit_rd; // read of the index or the data port
    assign ip_sel = color_sel_i ? RTH_COLOR_INDEX_PORT : RTH_MONO_INDEX_PORT;
    assign idx_rd = io_rd_i && (io_addr_i == ip_sel);
    assign hit_rd = idx_rd || (io_rd_i && (io_addr_i == ip_sel + 16'h0001));
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);
    chk_read_answer: assert property (hit_rd |=> io_rvalid_o)
        else $error("port read got no answer");
    chk_rvalid_only: assert property (!hit_rd |=> !io_rvalid_o)
        else $error("answer without a port read");
    chk_rdata_hold: assert property (!io_rvalid_o |-> $stable(io_rdata_o))
        else $error("read data moved without a read");
    chk_index_rsvd: assert property (idx_rd |=> io_rdata_o[7:5] == 3'h0)
        else $error("index upper bits not zero");
    chk_tick_eight: assert property (char_tick_o && dot8_sel_i |=> !char_tick_o [*7] ##1 char_tick_o)
        else $error("8-dot character has wrong length");
    chk_tick_nine: assert property (char_tick_o && !dot8_sel_i |=> !char_tick_o [*8] ##1 char_tick_o)
        else $error("9-dot character has wrong length");
    chk_count_step: assert property ($changed(hcount_o) |-> hcount_o == $past(hcount_o) + 1'b1 || hcount_o == '0)
        else $error("counter skipped a value");
    chk_count_hold: assert property ($changed(hcount_o) |=> $stable(hcount_o) [*7])
        else $error("counter moved within a character");
    chk_blank_char: assert property ($changed(hblank_o) |=> $stable(hblank_o) [*7])
        else $error("blank moved within a character");
    chk_sync_char: assert property ($changed(hsync_o) |=> $stable(hsync_o) [*7])
        else $error("retrace moved within a character");
    chk_den_char: assert property ($changed(disp_en_o) |=> $stable(disp_en_o) [*7])
        else $error("enable moved within a character");
    cover property (io_rvalid_o);
    cover property (char_tick_o && dot8_sel_i);
    cover property ($rose(hsync_o) && hblank_o);
endmodule

bind rth_htiming rth_htiming_monitor #(.COUNT_W(COUNT_W)) rth_htiming_monitor_i (
    .core_clk_i, .arst_n_i, .io_addr_i, .io_rd_i, .io_rdata_o, .io_rvalid_o, .color_sel_i,
    .dot8_sel_i, .char_tick_o, .hcount_o, .hblank_o, .hsync_o, .disp_en_o);

/* dv/rth_htiming_tb_top.sv */
// testbench: register access, write locks and measured horizontal timing
`timescale 1ns/1ns
module rth_htiming_tb_top;
    import rth_pkg::*;
    logic        core_clk_i = 1'b0;
    logic        arst_n_i = 1'b0;
    logic [15:0] io_addr_i = 16'h0000;
    logic        io_wr_i = 1'b0, io_rd_i = 1'b0;
    logic [7:0]  io_wdata_i = 8'h00;
    logic        color_sel_i = 1'b1, ext_lock_i = 1'b0, vr_protect_i = 1'b0;
    logic        vga_mode_i = 1'b1, dot8_sel_i = 1'b0;
    logic [7:0]  io_rdata_o;
    logic        io_rvalid_o, char_tick_o, hblank_o, hsync_o, disp_en_o;
    logic [8:0]  hcount_o;
    int          ln, sy, bl, de, ds; // panel measurements
    int          num_errors = 0, compares = 0, cyc = 0;
    logic [31:0] seed = 32'h6d92; // xorshift state
    logic [7:0]  sh [6]; // expected register contents
    rth_htiming rth_htiming_i (.core_clk_i, .arst_n_i, .io_addr_i, .io_wr_i, .io_rd_i, .io_wdata_i,
        .io_rdata_o, .io_rvalid_o, .color_sel_i, .ext_lock_i, .vr_protect_i, .vga_mode_i, .dot8_sel_i,
        .char_tick_o, .hcount_o, .hblank_o, .hsync_o, .disp_en_o);
    rth_panel_model rth_panel_model_i (.core_clk_i, .hsync_i(hsync_o), .hblank_i(hblank_o),
        .disp_en_i(disp_en_o), .line_dots_o(ln), .sync_dots_o(sy), .blank_dots_o(bl),
        .den_dots_o(de), .den_sync_o(ds));
    initial forever #10 core_clk_i = ~core_clk_i;
    // hang guard
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 40000) begin
            num_errors++;
            wrap_up();
        end
    end
    function automatic int rnd(input int span);
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return int'(seed % 32'(span));
    endfunction
    function automatic logic [7:0] rval(input int i);
        return 8'(rnd(256)) & ((i == 3) ? RTH_EBLANK_WMASK : 8'hff);
    endfunction
    function automatic int exp_dots(input int chars);
        return chars * int'(dot8_sel_i ? RTH_DOTS_NARROW : RTH_DOTS_WIDE);
    endfunction
    function automatic logic [15:0] ip();
        return color_sel_i ? RTH_COLOR_INDEX_PORT : RTH_MONO_INDEX_PORT;
    endfunction
    function automatic logic [15:0] dp();
        return color_sel_i ? RTH_COLOR_DATA_PORT : RTH_MONO_DATA_PORT;
    endfunction
    task automatic chk_reg(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_dots(input string what, input int exp, input int got);
        compares++;
        if (got != exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
        io_addr_i = a;
        io_wdata_i = d;
        io_wr_i = 1'b1;
        @(posedge core_clk_i);
        #2 io_wr_i = 1'b0;
        @(posedge core_clk_i);
        #2;
    endtask
    task automatic io_rd(input logic [15:0] a, output logic [7:0] d, output logic v);
        io_addr_i = a;
        io_rd_i = 1'b1;
        @(posedge core_clk_i);
        #2 io_rd_i = 1'b0;
        d = io_rdata_o;
        v = io_rvalid_o;
        @(posedge core_clk_i);
        #2;
    endtask
    task automatic reg_wr(input logic [4:0] idx, input logic [7:0] d);
        io_wr(ip(), {3'h0, idx});
        io_wr(dp(), d);
    endtask
    task automatic reg_chk(input logic [4:0] idx, input logic [7:0] exp);
        logic [7:0] d;
        logic       v;
        io_wr(ip(), {3'h0, idx});
        io_rd(dp(), d, v);
        chk_reg("register", exp, d);
        chk_reg("answer", 8'h01, {7'h0, v});
    endtask
    task automatic do_reset(input logic m);
        arst_n_i = 1'b0;
        dot8_sel_i = m;
        repeat (6) @(posedge core_clk_i);
        #2 arst_n_i = 1'b1;
    endtask
    task automatic wrap_up();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        int         i, k, tot, dn, w, ss, sw, sk, dl;
        logic [7:0] d;
        logic       v;
        do_reset(1'b0);
        for (i = 0; i < 6; i++) reg_chk(i[4:0], RTH_REG_RESET);
        k = 6 + rnd(26);
        reg_chk(k[4:0], RTH_READ_UNMAPPED);
        io_rd(ip(), d, v);
        chk_reg("index", {3'h0, k[4:0]}, d);
        io_rd(16'h03c5, d, v);
        chk_reg("stray answer", 8'h00, {7'h0, v});
        // readback on both port sets; the other set's data port must be ignored
        for (i = 0; i < 12; i++) begin
            color_sel_i = i[0];
            k = rnd(6);
            d = rval(k);
            reg_wr(k[4:0], d);
            io_wr(color_sel_i ? RTH_MONO_DATA_PORT : RTH_COLOR_DATA_PORT, ~d);
            reg_chk(k[4:0], d);
        end
        for (i = 0; i < 6; i++) begin
            sh[i] = rval(i);
            reg_wr(i[4:0], sh[i]);
        end
        // each lock source alone keeps 02..05, never 00/01
        for (k = 0; k < 3; k++) begin
            ext_lock_i = (k == 0);
            vr_protect_i = (k == 1);
            vga_mode_i = (k != 2);
            for (i = 0; i < 6; i++) begin
                d = rval(i);
                reg_wr(i[4:0], d);
                if (i < 2) sh[i] = d;
            end
            for (i = 0; i < 6; i++) reg_chk(i[4:0], sh[i]);
        end
        ext_lock_i = 1'b0;
        vr_protect_i = 1'b0;
        vga_mode_i = 1'b1;
        // timing: every skew and delay code, both character widths
        for (k = 0; k < 8; k++) begin
            do_reset(k[2]);
            tot = 60 + rnd(20);
            dn = 10 + rnd(10);
            w = 1 + rnd(40);
            ss = dn + 4;
            sw = 1 + rnd(8);
            sk = k % 4;
            dl = (k * 3 + 1) % 4;
            reg_wr(5'h00, 8'(tot));
            reg_wr(5'h01, 8'(dn));
            reg_wr(5'h02, 8'(dn + 2));
            reg_wr(5'h03, {1'b0, 2'(sk), 5'(w)});
            reg_wr(5'h04, 8'(ss));
            reg_wr(5'h05, {1'(w >> 5), 2'(dl), 5'(ss + sw)});
            repeat (exp_dots(3 * (tot + 5))) @(posedge core_clk_i);
            #2;
            chk_dots("line", exp_dots(tot + 5), ln);
            chk_dots("retrace", exp_dots(sw), sy);
            chk_dots("blank", exp_dots(w), bl);
            chk_dots("enable", exp_dots(dn), de);
            chk_dots("enable to retrace", exp_dots(ss + dl - sk), ds);
        end
        wrap_up();
    end
endmodule

/* dv/rth_panel_model.sv */
// partner: display sink that measures line, retrace, blank and enable lengths in dots
`timescale 1ns/1ns
module rth_panel_model (
    input  wire logic core_clk_i, // dot clock
    input  wire logic hsync_i, // retrace level
    input  wire logic hblank_i, // blank level
    input  wire logic disp_en_i, // display enable level
    output int        line_dots_o, // retrace start to retrace start
    output int        sync_dots_o, // retrace width
    output int        blank_dots_o, // blank width
    output int        den_dots_o, // enable width
    output int        den_sync_o // enable start to retrace start
);
    int   now; // free running dot count
    int   t_s, t_b, t_d; // time of the last rising level
    logic s_q, b_q, d_q; // levels one dot ago
    // timestamp each rising edge of the three levels; falling edges record widths
    always @(posedge core_clk_i) begin
        now <= now + 1;
        s_q <= hsync_i;
        b_q <= hblank_i;
        d_q <= disp_en_i;
        if (hsync_i && !s_q) begin
            line_dots_o <= now - t_s;
            den_sync_o <= now - t_d;
            t_s <= now;
        end
        if (!hsync_i && s_q) sync_dots_o <= now - t_s;
        if (hblank_i && !b_q) t_b <= now;
        if (!hblank_i && b_q) blank_dots_o <= now - t_b;
        if (disp_en_i && !d_q) t_d <= now;
        if (!disp_en_i && d_q) den_dots_o <= now - t_d;
    end
endmodule

/* inc/rth_dly_if.sv */
// interface: one programmable character-clock delay line between the timing core and its delay module
`timescale 1ns/1ns
interface rth_dly_if;
    logic       tick;   // character clock strobe
    logic       din;    // undelayed timing level
    logic [1:0] sel;    // delay code in character clocks
    logic       dout;   // delayed timing level

    // timing core side
    modport drv  (output tick, output din, output sel, input dout);
    // delay module side
    modport line (input tick, input din, input sel, output dout);
endinterface

/* inc/rth_pkg.sv */
// package: port addresses, register indices, field positions and timing constants for horizontal timing
package rth_pkg;

    // i/o port addresses; the middle digit follows the mono/colour select
    localparam logic [15:0] RTH_MONO_INDEX_PORT  = 16'h03b4;  // index port, monochrome
    localparam logic [15:0] RTH_MONO_DATA_PORT   = 16'h03b5;  // data port, monochrome
    localparam logic [15:0] RTH_COLOR_INDEX_PORT = 16'h03d4;  // index port, colour
    localparam logic [15:0] RTH_COLOR_DATA_PORT  = 16'h03d5;  // data port, colour

    // index pointer width: low five bits select, upper three read as zero
    localparam int          RTH_INDEX_W          = 5;
    localparam logic [2:0]  RTH_INDEX_RSVD       = 3'h0;

    // register indices behind the data port
    localparam logic [4:0]  RTH_IDX_HORIZONTAL_TOTAL      = 5'h00;
    localparam logic [4:0]  RTH_IDX_DISPLAY_END_COUNT     = 5'h01;
    localparam logic [4:0]  RTH_IDX_BLANK_START_COUNT     = 5'h02;
    localparam logic [4:0]  RTH_IDX_BLANK_END_AND_SKEW    = 5'h03;
    localparam logic [4:0]  RTH_IDX_RETRACE_START_COUNT   = 5'h04;
    localparam logic [4:0]  RTH_IDX_RETRACE_END_AND_DELAY = 5'h05;

    // reset value of every timing register and of the index pointer; read value of an unmapped index
    localparam logic [7:0]  RTH_REG_RESET        = 8'h00;
    localparam logic [7:0]  RTH_READ_UNMAPPED    = 8'h00;

    // field positions inside the end-blank and end-retrace registers
    localparam int          RTH_SKEW_LSB         = 5;   // skew / delay code, low bit
    localparam int          RTH_SKEW_MSB         = 6;   // skew / delay code, high bit
    localparam int          RTH_END_LOW_MSB      = 4;   // five-bit end field, top bit
    localparam int          RTH_BLANK_MSB_BIT    = 7;   // sixth end-blank bit in end-retrace
    localparam logic [7:0]  RTH_EBLANK_WMASK     = 8'h7f; // bit 7 of end-blank is reserved

    // horizontal total bias: programmed value is total characters less this
    localparam logic [8:0]  RTH_TOTAL_BIAS       = 9'h005;

    // character clock width in dots
    localparam logic [3:0]  RTH_DOTS_WIDE        = 4'h9;
    localparam logic [3:0]  RTH_DOTS_NARROW      = 4'h8;

    // longest skew or delay in character clocks
    localparam int          RTH_MAX_DELAY        = 3;

endpackage

/* verilog/rth_delay_line.sv */
// module: delays one timing level by 0 to 3 character clocks
`timescale 1ns/1ns
module rth_delay_line #(
    parameter int MAX_DELAY = rth_pkg::RTH_MAX_DELAY
) (
    input  wire logic core_clk_i,   // dot clock
    input  wire logic arst_n_i,     // asynchronous reset, active low
    rth_dly_if.line   dly           // delay request and result
);
    import rth_pkg::*;

    logic [MAX_DELAY-1:0] tap_q;    // one tap per character clock of delay
    logic [1:0]           sel_q;    // delay code, taken only between characters

    // shift the level along on each character clock
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tap_q <= '0;
            sel_q <= '0;
        end else if (dly.tick) begin
            tap_q <= {tap_q[MAX_DELAY-2:0], dly.din};
            sel_q <= dly.sel;
        end
    end

    // pick the tap; code zero passes the level straight through
    always_comb begin
        if (sel_q == 2'h0) begin
            dly.dout = dly.din;
        end else begin
            dly.dout = tap_q[sel_q - 2'h1];
        end
    end
endmodule

/* verilog/rth_htiming.sv */
// module: horizontal timing of the raster timing controller with its index/data register ports
`timescale 1ns/1ns
module rth_htiming #(
    parameter int COUNT_W = 9       // width of the horizontal character counter
) (
    input  wire logic               core_clk_i,     // dot clock, one dot per edge
    input  wire logic               arst_n_i,       // asynchronous reset, active low
    input  wire logic [15:0]        io_addr_i,      // host i/o address
    input  wire logic               io_wr_i,        // host i/o write strobe, one cycle
    input  wire logic               io_rd_i,        // host i/o read strobe, one cycle
    input  wire logic [7:0]         io_wdata_i,     // host write data
    output logic      [7:0]         io_rdata_o,     // host read data, registered
    output logic                    io_rvalid_o,    // read data valid, one cycle
    input  wire logic               color_sel_i,    // miscellaneous output bit 0: 1 colour, 0 mono
    input  wire logic               ext_lock_i,     // extended lock register bit 5
    input  wire logic               vr_protect_i,   // vertical retrace end register bit 7
    input  wire logic               vga_mode_i,     // 1 vga mode, 0 legacy text-controller mode
    input  wire logic               dot8_sel_i,     // clocking mode bit 0: 1 eight dots, 0 nine
    output logic                    char_tick_o,    // character clock strobe, registered
    output logic      [COUNT_W-1:0] hcount_o,       // horizontal character count, registered
    output logic                    hblank_o,       // horizontal blanking, active high
    output logic                    hsync_o,        // horizontal retrace, active high, delayed
    output logic                    disp_en_o       // display enable, active high, skewed
);
    import rth_pkg::*;

    // ---- register file ----
    logic [RTH_INDEX_W-1:0] index_q;            // timing index pointer
    logic [7:0]             horizontal_total_q; // total characters less five
    logic [7:0]             display_end_count_q;// displayed characters per line
    logic [7:0]             blank_start_count_q;// blanking start position
    logic [7:0]             blank_end_and_skew_q;// end-blank low bits and display skew
    logic [7:0]             retrace_start_count_q;// retrace start position
    logic [7:0]             retrace_end_and_delay_q;// end-retrace, blank msb, retrace delay

    // ---- port decode ----
    logic [15:0]            index_port;         // index port for current configuration
    logic [15:0]            data_port;          // data port for current configuration
    logic                   index_hit;          // access targets the index port
    logic                   data_hit;           // access targets the data port
    logic                   idx_wr;             // index port write
    logic                   data_wr;            // data port write
    logic                   timing_locked;      // blank/retrace registers write-protected

    // ---- timing core ----
    logic [3:0]             dot_cnt_q;          // dot position within the character
    logic [3:0]             dot_last;           // last dot of the character
    logic                   char_tick;          // one-dot strobe per character clock
    logic [COUNT_W-1:0]     hcnt_q;             // horizontal character counter
    logic [COUNT_W-1:0]     hcnt_last;          // last count of a scan line
    logic [COUNT_W-1:0]     hcnt_nxt;           // count of the next character
    logic                   line_end;           // counter wraps on this character clock
    logic                   de_q;               // display enable before skew
    logic                   blank_q;            // blanking level
    logic [5:0]             blank_w_q;          // characters blanked so far
    logic [5:0]             blank_w_next;       // blank width after this character
    logic [5:0]             blank_end;          // six-bit blank width value
    logic                   retrace_q;          // retrace level before delay
    logic [4:0]             retrace_end;        // five-bit retrace end field
    logic [7:0]             rd_mux;             // data port read value

    // the two delay lines, one for display enable and one for retrace
    rth_dly_if de_dly ();
    rth_dly_if rt_dly ();

    // ---- i/o decode ----
    // the middle digit of both port addresses follows the mono/colour select
    always_comb begin
        if (color_sel_i) begin
            index_port = RTH_COLOR_INDEX_PORT;
            data_port  = RTH_COLOR_DATA_PORT;
        end else begin
            index_port = RTH_MONO_INDEX_PORT;
            data_port  = RTH_MONO_DATA_PORT;
        end
    end

    assign index_hit = (io_addr_i == index_port);
    assign data_hit  = (io_addr_i == data_port);
    assign idx_wr    = io_wr_i && index_hit;
    assign data_wr   = io_wr_i && data_hit;

    // blank and retrace registers hold their value under either lock or outside vga mode
    assign timing_locked = ext_lock_i || vr_protect_i || !vga_mode_i;

    // ---- index pointer ----
    // only the low five bits are kept; the upper three read back as zero
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            index_q <= RTH_REG_RESET[RTH_INDEX_W-1:0];
        end else if (idx_wr) begin
            index_q <= io_wdata_i[RTH_INDEX_W-1:0];
        end
    end

    // ---- total and display-end registers ----
    // these two apply in both modes and are never locked here
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            horizontal_total_q  <= RTH_REG_RESET;
            display_end_count_q <= RTH_REG_RESET;
        end else if (data_wr) begin
            // the stored index picks the target
            if (index_q == RTH_IDX_HORIZONTAL_TOTAL) begin
                horizontal_total_q <= io_wdata_i;
            end
            if (index_q == RTH_IDX_DISPLAY_END_COUNT) begin
                display_end_count_q <= io_wdata_i;
            end
        end
    end

    // ---- blank and retrace registers ----
    // writes are dropped silently while locked; reads still work
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            blank_start_count_q     <= RTH_REG_RESET;
            blank_end_and_skew_q    <= RTH_REG_RESET;
            retrace_start_count_q   <= RTH_REG_RESET;
            retrace_end_and_delay_q <= RTH_REG_RESET;
        end else if (data_wr && !timing_locked) begin
            case (index_q)
                RTH_IDX_BLANK_START_COUNT: begin
                    blank_start_count_q <= io_wdata_i;
                end
                RTH_IDX_BLANK_END_AND_SKEW: begin
                    // reserved top bit is not stored
                    blank_end_and_skew_q <= io_wdata_i & RTH_EBLANK_WMASK;
                end
                RTH_IDX_RETRACE_START_COUNT: begin
                    retrace_start_count_q <= io_wdata_i;
                end
                RTH_IDX_RETRACE_END_AND_DELAY: begin
                    retrace_end_and_delay_q <= io_wdata_i;
                end
                default: begin
                    // other indices belong to other blocks
                end
            endcase
        end
    end

    // ---- read path ----
    // data port read returns the register under the index, zero elsewhere
    always_comb begin
        case (index_q)
            RTH_IDX_HORIZONTAL_TOTAL:      rd_mux = horizontal_total_q;
            RTH_IDX_DISPLAY_END_COUNT:     rd_mux = display_end_count_q;
            RTH_IDX_BLANK_START_COUNT:     rd_mux = blank_start_count_q;
            RTH_IDX_BLANK_END_AND_SKEW:    rd_mux = blank_end_and_skew_q;
            RTH_IDX_RETRACE_START_COUNT:   rd_mux = retrace_start_count_q;
            RTH_IDX_RETRACE_END_AND_DELAY: rd_mux = retrace_end_and_delay_q;
            default:                       rd_mux = RTH_READ_UNMAPPED;
        endcase
    end

    // read data is captured one edge after the strobe and then held
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            io_rdata_o  <= RTH_READ_UNMAPPED;
            io_rvalid_o <= 1'b0;
        end else begin
            io_rvalid_o <= io_rd_i && (index_hit || data_hit);
            if (io_rd_i && index_hit) begin
                io_rdata_o <= {RTH_INDEX_RSVD, index_q};
            end else if (io_rd_i && data_hit) begin
                io_rdata_o <= rd_mux;
            end
        end
    end

    // ---- character clock ----
    // the divider counts dots; width follows the dot select bit
    assign dot_last  = (dot8_sel_i ? RTH_DOTS_NARROW : RTH_DOTS_WIDE) - 4'h1;
    assign char_tick = (dot_cnt_q >= dot_last); // a narrowing switch never stalls the divider

    // dot counter, restarts each character
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dot_cnt_q <= 4'h0;
        end else if (char_tick) begin
            dot_cnt_q <= 4'h0;
        end else begin
            dot_cnt_q <= dot_cnt_q + 4'h1;
        end
    end

    // ---- horizontal character counter ----
    // a line is programmed total plus five characters, so the last count is total plus four
    assign hcnt_last = COUNT_W'({1'b0, horizontal_total_q} + RTH_TOTAL_BIAS - 9'h001);
    assign line_end  = (hcnt_q >= hcnt_last); // a shortened total still wraps
    assign hcnt_nxt  = line_end ? '0 : hcnt_q + COUNT_W'(1);

    // counter steps once per character clock and wraps to zero
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hcnt_q <= '0;
        end else if (char_tick) begin
            hcnt_q <= hcnt_nxt;
        end
    end

    // ---- display enable ----
    // decided per character so a register write never splits a character
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            de_q <= 1'b0;
        end else if (char_tick) begin
            de_q <= (hcnt_nxt < COUNT_W'(display_end_count_q));
        end
    end

    // ---- horizontal blanking ----
    // six-bit width value: five bits from end-blank, msb from end-retrace
    assign blank_end    = {retrace_end_and_delay_q[RTH_BLANK_MSB_BIT],
                           blank_end_and_skew_q[RTH_END_LOW_MSB:0]};
    assign blank_w_next = blank_w_q + 6'h01;

    // blanking starts on the start match and lasts W characters; W of zero gives 64
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            blank_q   <= 1'b0;
            blank_w_q <= 6'h00;
        end else if (char_tick) begin
            if (hcnt_nxt == COUNT_W'(blank_start_count_q)) begin
                // start wins over an end in the same character
                blank_q   <= 1'b1;
                blank_w_q <= 6'h00;
            end else if (blank_q) begin
                blank_w_q <= blank_w_next;
                if (blank_w_next == blank_end) begin
                    blank_q <= 1'b0;
                end
            end
        end
    end

    // ---- horizontal retrace ----
    assign retrace_end = retrace_end_and_delay_q[RTH_END_LOW_MSB:0];

    // retrace starts on the full eight-bit match and ends on a five-bit match
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            retrace_q <= 1'b0;
        end else if (char_tick) begin
            if (hcnt_nxt == COUNT_W'(retrace_start_count_q)) begin
                retrace_q <= 1'b1;
            end else if (hcnt_nxt[RTH_END_LOW_MSB:0] == retrace_end) begin
                retrace_q <= 1'b0;
            end
        end
    end

    // ---- skew and delay lines ----
    // display enable skew code from end-blank bits 6:5
    assign de_dly.tick = char_tick;
    assign de_dly.din  = de_q;
    assign de_dly.sel  = blank_end_and_skew_q[RTH_SKEW_MSB:RTH_SKEW_LSB];

    // retrace delay code from end-retrace bits 6:5
    assign rt_dly.tick = char_tick;
    assign rt_dly.din  = retrace_q;
    assign rt_dly.sel  = retrace_end_and_delay_q[RTH_SKEW_MSB:RTH_SKEW_LSB];

    rth_delay_line #(
        .MAX_DELAY (RTH_MAX_DELAY)
    ) u_de_skew (
        .core_clk_i (core_clk_i),
        .arst_n_i   (arst_n_i),
        .dly        (de_dly.line)
    );

    rth_delay_line #(
        .MAX_DELAY (RTH_MAX_DELAY)
    ) u_rt_delay (
        .core_clk_i (core_clk_i),
        .arst_n_i   (arst_n_i),
        .dly        (rt_dly.line)
    );

    // ---- output registers ----
    // every timing output leaves through a flop, one dot after its source
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            char_tick_o <= 1'b0;
            hcount_o    <= '0;
            hblank_o    <= 1'b0;
            hsync_o     <= 1'b0;
            disp_en_o   <= 1'b0;
        end else begin
            char_tick_o <= char_tick;
            hcount_o    <= hcnt_q;
            hblank_o    <= blank_q;
            hsync_o     <= rt_dly.dout;
            disp_en_o   <= de_dly.dout;
        end
    end

endmodule
